// ---- hw/mcsp_dev.sv ----
// Device end: serial slave with register file and pipelined table port
//
// Summary of operation
// - One transfer is address byte plus four data bytes
// - Always exchange all 32 data bits
// - Address bit 39 set means write, clear read
// - Data bits of a read are ignored
// - Lower seven address bits index the register
// - Values right aligned, signed as two's complement
// - Write-only, read-write and read-only registers exist
// - Position read uses 0x01, write uses 0x81
// - Configuration changes only through serial writes
// - Table read data arrives one datagram later
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module mcsp_dev
  import mcsp_pkg::*;
#(
  parameter int          LUT_DEPTH  = 8192,
  parameter int          LUT_AW     = 13,
  parameter int          LUT_DW     = 12,
  parameter logic [31:0] TYPE_ID    = 32'h0000_0a5a  // Arbitrary identification value
)
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  mcsp_if.dev                                link,
  input  wire logic                          step_i,
  input  wire logic                          dir_i,
  input  wire logic [mcsp_pkg::DATA_BITS-1:0] status_i,
  output logic                               cfg_wr_o,
  output logic [mcsp_pkg::IDX_BITS-1:0]      cfg_idx_o,
  output logic [mcsp_pkg::DATA_BITS-1:0]     cfg_data_o,
  output logic [mcsp_pkg::DATA_BITS-1:0]     mode_o,
  output logic [mcsp_pkg::DATA_BITS-1:0]     actual_position_o
);
  import mcsp_pkg::*;

  // Two-stage synchronisers for the link pins
  logic sclk_q1;
  logic sclk_s;
  logic sclk_d;
  logic cs_q1;
  logic cs_s;
  logic cs_d;
  logic mosi_q1;
  logic mosi_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_q1 <= 1'b0;
      sclk_s  <= 1'b0;
      sclk_d  <= 1'b0;
      cs_q1   <= 1'b1;
      cs_s    <= 1'b1;
      cs_d    <= 1'b1;
      mosi_q1 <= 1'b0;
      mosi_s  <= 1'b0;
    end
    else
    begin
      sclk_q1 <= link.sclk;
      sclk_s  <= sclk_q1;
      sclk_d  <= sclk_s;
      cs_q1   <= link.cs_n;
      cs_s    <= cs_q1;
      cs_d    <= cs_s;
      mosi_q1 <= link.mosi;
      mosi_s  <= mosi_q1;
    end
  end

  // Edge detection on the synchronised pins
  wire sel_w     = ~cs_s;
  wire cs_fall   = ~cs_s & cs_d;
  wire cs_rise   = cs_s & ~cs_d;
  wire sclk_rise = sel_w & sclk_s & ~sclk_d;
  wire sclk_fall = sel_w & ~sclk_s & sclk_d;

  // Receive and transmit shifters and bit counter
  logic [DG_BITS-1:0]   rx_sh;
  logic [CNT_W-1:0]     bit_cnt;
  logic [DATA_BITS-1:0] tx_sh;
  logic                 miso_r;

  // Register state
  logic [DATA_BITS-1:0] mode_r;
  logic [DATA_BITS-1:0] pos_r;
  logic [LUT_AW-1:0]    lut_ptr;
  logic [LUT_DW-1:0]    lut_rd_q;
  logic [LUT_DW-1:0]    lut_mem [LUT_DEPTH];

  // Index of the register as soon as the eighth bit arrives
  wire [IDX_BITS-1:0] idx_now = {rx_sh[5:0], mosi_s};
  wire                addr_done = sclk_rise & (bit_cnt == CNT_ADDR_DONE);

  // Read multiplexer; write-only and unmapped indices read zero
  logic [DATA_BITS-1:0] rd_mux;
  always_comb
  begin
    case (idx_now)
      REG_MODE:            rd_mux = mode_r;
      REG_ACTUAL_POSITION: rd_mux = pos_r;
      REG_STATUS:          rd_mux = status_i;
      REG_LUT_RD:          rd_mux = {{(DATA_BITS-LUT_DW){1'b0}}, lut_rd_q};
      REG_TYPE_VERSION:    rd_mux = TYPE_ID;
      default:             rd_mux = '0;
    endcase
  end

  // Decoding of a finished datagram
  wire                 dg_ok   = cs_rise & (bit_cnt == CNT_FULL);
  wire                 is_wr   = rx_sh[DIR_POS];
  wire [IDX_BITS-1:0]  dg_idx  = rx_sh[DG_BITS-2:DATA_BITS];
  wire [DATA_BITS-1:0] dg_data = rx_sh[DATA_BITS-1:0];
  wire                 wr_ok   = dg_ok & is_wr;
  wire                 rd_ok   = dg_ok & ~is_wr;
  wire wr_mode   = wr_ok & (dg_idx == REG_MODE);
  wire wr_pos    = wr_ok & (dg_idx == REG_ACTUAL_POSITION);
  wire wr_ptr    = wr_ok & (dg_idx == REG_LUT_PTR);
  wire wr_lut    = wr_ok & (dg_idx == REG_LUT_WR);
  wire rd_lut    = rd_ok & (dg_idx == REG_LUT_RD);
  wire wr_local  = wr_mode | wr_pos | wr_ptr | wr_lut;

  // Shift in on rising serial clock; count runs past forty so long frames fail
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_sh   <= '0;
      bit_cnt <= '0;
    end
    else if (cs_fall)
    begin
      rx_sh   <= '0;
      bit_cnt <= '0;
    end
    else if (sclk_rise && bit_cnt != {CNT_W{1'b1}})
    begin
      rx_sh   <= {rx_sh[DG_BITS-2:0], mosi_s};
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // Answer word loaded after address, shifted out on falling edges
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_sh  <= '0;
      miso_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      tx_sh  <= '0;
      miso_r <= 1'b0;
    end
    else if (addr_done)
      tx_sh <= rd_mux;
    else if (sclk_fall && bit_cnt > CNT_ADDR_DONE && bit_cnt != CNT_FULL)
    begin
      miso_r <= tx_sh[DATA_BITS-1];
      tx_sh  <= {tx_sh[DATA_BITS-2:0], 1'b0};
    end
    else if (sclk_fall)
      miso_r <= 1'b0;
  end

  // Mode and position registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= MODE_RESET;
      pos_r  <= POS_RESET;
    end
    else
    begin
      if (wr_mode)
        mode_r <= dg_data;
      if (wr_pos)
        pos_r <= dg_data;
      else if (step_i)
        pos_r <= dir_i ? pos_r - 32'h1 : pos_r + 32'h1;
    end
  end

  // Table pointer advances on each table write or read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lut_ptr <= '0;
    else if (wr_ptr)
      lut_ptr <= dg_data[LUT_AW-1:0];
    else if (wr_lut || rd_lut)
      lut_ptr <= lut_ptr + 1'b1;
  end

  // Table memory; read result waits for the next datagram
  always_ff @(posedge clk_i)
  begin
    if (wr_lut)
      lut_mem[lut_ptr] <= dg_data[LUT_DW-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lut_rd_q <= '0;
    else if (rd_lut)
      lut_rd_q <= lut_mem[lut_ptr];
  end

  // Other writes go out as write-only configuration strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_wr_o   <= 1'b0;
      cfg_idx_o  <= '0;
      cfg_data_o <= '0;
    end
    else
    begin
      cfg_wr_o <= wr_ok & ~wr_local;
      if (wr_ok && !wr_local)
      begin
        cfg_idx_o  <= dg_idx;
        cfg_data_o <= dg_data;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_o            <= MODE_RESET;
      actual_position_o <= POS_RESET;
    end
    else
    begin
      mode_o            <= mode_r;
      actual_position_o <= pos_r;
    end
  end

  assign link.miso = miso_r;
endmodule

// ---- hw/mcsp_host.sv ----
// Host end: Wishbone-controlled serial master for 40-bit datagrams
`timescale 1ns/1ps
module mcsp_host
  import mcsp_pkg::*;
#(
  parameter int HALF_CYC = mcsp_pkg::SCLK_HALF_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  mcsp_if.host             link
);
  import mcsp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} mcsp_hstate_e;

  mcsp_hstate_e         state;
  logic [7:0]           div_cnt;
  logic [CNT_W-1:0]     bit_cnt;
  logic [DG_BITS-1:0]   tx_sh;
  logic [DATA_BITS-1:0] rx_sh;
  logic [DATA_BITS-1:0] tx_data;
  logic [DATA_BITS-1:0] rx_data;
  logic                 done;
  logic                 miso_q1;
  logic                 miso_s;
  logic                 sclk_r;
  logic                 cs_n_r;

  // Bus decode
  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req   = req & wb_we_i;
  wire wr_ctrl  = wr_req & (wb_adr_i == HOFS_CTRL) & (state == H_IDLE);
  wire wr_tx    = wr_req & (wb_adr_i == HOFS_TXDATA);
  wire busy     = (state != H_IDLE);
  wire tick     = (div_cnt == 8'(HALF_CYC - 1));
  wire last_bit = (bit_cnt == CNT_FULL - 6'h01);
  wire fin      = (state == H_TAIL) & tick;

  // Read multiplexer
  logic [31:0] rd_mux;
  always_comb
  begin
    case (wb_adr_i)
      HOFS_TXDATA: rd_mux = tx_data;
      HOFS_RXDATA: rd_mux = rx_data;
      HOFS_STATUS: rd_mux = {30'h0, done, busy};
      default:     rd_mux = 32'h0;
    endcase
  end

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= rd_mux;
    end
  end

  // Transmit word with byte enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_data <= 32'h0;
    else if (wr_tx)
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          tx_data[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
  end

  // Done flag: completion wins over a clear by a new start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done <= 1'b0;
    else if (fin)
      done <= 1'b1;
    else if (wr_ctrl)
      done <= 1'b0;
  end

  // Received data line synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      miso_q1 <= 1'b0;
      miso_s  <= 1'b0;
    end
    else
    begin
      miso_q1 <= link.miso;
      miso_s  <= miso_q1;
    end
  end

  // Half-period divider runs while a frame is open
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !busy || tick)
      div_cnt <= 8'h0;
    else
      div_cnt <= div_cnt + 8'h1;
  end

  // Frame sequencer: select, 40 clock pulses, closing gap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state   <= H_IDLE;
      bit_cnt <= '0;
      tx_sh   <= '0;
      rx_sh   <= '0;
      rx_data <= '0;
      sclk_r  <= 1'b0;
      cs_n_r  <= 1'b1;
    end
    else
    begin
      case (state)
        H_IDLE:
          if (wr_ctrl)
          begin
            tx_sh   <= {wb_dat_i[7:0], tx_data};
            bit_cnt <= '0;
            cs_n_r  <= 1'b0;
            state   <= H_LOW;
          end
        H_LOW:
          if (tick)
          begin
            sclk_r <= 1'b1;
            state  <= H_HIGH;
            if (bit_cnt >= CNT_W'(ADDR_BITS))
              rx_sh <= {rx_sh[DATA_BITS-2:0], miso_s};
          end
        H_HIGH:
          if (tick)
          begin
            sclk_r  <= 1'b0;
            bit_cnt <= bit_cnt + 6'h01;
            tx_sh   <= {tx_sh[DG_BITS-2:0], 1'b0};
            state   <= last_bit ? H_TAIL : H_LOW;
          end
        H_TAIL:
          if (tick)
          begin
            cs_n_r  <= 1'b1;
            rx_data <= rx_sh;
            state   <= H_IDLE;
          end
        default:
          state <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = tx_sh[DG_BITS-1];
endmodule

// ---- shared/mcsp_if.sv ----
// Four-wire serial link between host and device
`timescale 1ns/1ps
interface mcsp_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;

  // Host drives clock, select and data out
  modport host (output sclk, output cs_n, output mosi, input miso);
  // Device answers on its data line
  modport dev  (input sclk, input cs_n, input mosi, output miso);
endinterface

// ---- shared/mcsp_pkg.sv ----
// Shared constants for the serial register datagram port
package mcsp_pkg;
  // Datagram layout, most significant bit first
  localparam int DG_BITS   = 40;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 32;
  localparam int IDX_BITS  = 7;
  localparam int DIR_POS   = 39;
  localparam int CNT_W     = 6;
  localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 6'h07;
  localparam logic [CNT_W-1:0] CNT_FULL      = 6'h28;

  // Device register indices
  localparam logic [IDX_BITS-1:0] REG_MODE            = 7'h00;
  localparam logic [IDX_BITS-1:0] REG_ACTUAL_POSITION = 7'h01;
  localparam logic [IDX_BITS-1:0] REG_STATUS          = 7'h0b;
  localparam logic [IDX_BITS-1:0] REG_LUT_PTR         = 7'h70;
  localparam logic [IDX_BITS-1:0] REG_LUT_WR          = 7'h71;
  localparam logic [IDX_BITS-1:0] REG_LUT_RD          = 7'h72;
  localparam logic [IDX_BITS-1:0] REG_TYPE_VERSION    = 7'h73;

  // Device reset values
  localparam logic [DATA_BITS-1:0] MODE_RESET = 32'h0000_0002;
  localparam logic [DATA_BITS-1:0] POS_RESET  = 32'h0000_0000;

  // Host Wishbone register byte offsets
  localparam logic [3:0] HOFS_CTRL   = 4'h0;
  localparam logic [3:0] HOFS_TXDATA = 4'h4;
  localparam logic [3:0] HOFS_RXDATA = 4'h8;
  localparam logic [3:0] HOFS_STATUS = 4'hc;
  localparam int HSTAT_BUSY = 0;
  localparam int HSTAT_DONE = 1;

  // Serial clock timing of the host end
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCLK_HALF_NS   = 400;
  localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- verif/mcsp_assertions.sv ----
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
module mcsp_assertions
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic       sclk_q;
  logic       cs_q;
  logic [5:0] rise_cnt;
  logic [5:0] fall_cnt;
  logic [3:0] since_evt;

  // Edge decode of clock and select
  wire rise = sclk & ~sclk_q;
  wire fall = ~sclk & sclk_q;
  wire evt  = fall | (~cs_n & cs_q);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Edge memory
  always_ff @(posedge clk_i)
  begin
    sclk_q <= sclk;
    cs_q   <= cs_n;
  end

  // Clock edges counted within one frame
  always_ff @(posedge clk_i)
  begin
    rise_cnt <= (rst_i | cs_n) ? 6'h00 : rise_cnt + {5'h00, rise};
    fall_cnt <= (rst_i | cs_n) ? 6'h00 : fall_cnt + {5'h00, fall};
  end

  // Cycles since the device last had cause to move its data line
  always_ff @(posedge clk_i)
    since_evt <= (rst_i | evt) ? 4'h0 : since_evt + {3'h0, ~&since_evt};

  // Lead-in after select, then one high phase of the clock
  sequence s_lead;
    !sclk[*4] ##[1:16] sclk;
  endsequence
  sequence s_high;
    sclk[*8] ##1 !sclk;
  endsequence

  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_lead_in: assert property ($fell(cs_n) |-> s_lead)
    else $error("bad lead-in after select");
  a_high_phase: assert property ($rose(sclk) |-> s_high)
    else $error("serial clock high phase wrong");
  a_mosi_held: assert property ($rose(sclk) |-> $stable(mosi)[*8])
    else $error("host data moved while clock high");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n[*3])
    else $error("select gap too short");
  a_frame_bits: assert property ($rose(cs_n) |-> rise_cnt == 6'h28 && fall_cnt == 6'h28)
    else $error("frame not forty bits");
  a_addr_quiet: assert property ($rose(sclk) && fall_cnt < 6'h08 |-> !miso)
    else $error("device data not zero in address byte");
  a_miso_timing: assert property ($changed(miso) |-> since_evt <= 4'h6)
    else $error("device data moved without a clock fall");
endmodule

// ---- verif/spi_register_datagram_port_test.sv ----
// Testbench: host and device ends joined over the serial link
`timescale 1ns/1ps
module spi_register_datagram_port_test;
  import mcsp_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0000_0c3c; // Arbitrary identification value
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [3:0]  wb_adr   = 4'h0;
  logic [3:0]  wb_sel   = 4'h0;
  logic [3:0]  sel_v    = 4'hf;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        step     = 1'b0;
  logic        dir      = 1'b0;
  logic [31:0] status   = 32'h0000_0015;
  logic        cfg_wr;
  logic [6:0]  cfg_idx;
  logic [31:0] cfg_data;
  logic [31:0] mode;
  logic [31:0] pos;
  logic [31:0] pos_b;
  logic [31:0] lut [3] = '{32'h0000_0abc, 32'h0000_0123, 32'h0000_0fff};
  int          cfg_pulses  = 0;
  int          miscompares = 0;
  int          checked     = 0;

  mcsp_if link_a ();
  mcsp_if link_b ();

  // Clock and idle levels of the hand-driven link
  always #25 clk_i = ~clk_i;
  initial {link_b.sclk, link_b.cs_n, link_b.mosi} = 3'b010;

  // Design ends and link checker
  mcsp_host mcsp_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_ack_o(wb_ack), .wb_dat_o(wb_dat_r), .link(link_a.host));
  mcsp_dev #(.LUT_DEPTH(64), .LUT_AW(6), .TYPE_ID(ID_VAL)) mcsp_dev_i (.clk_i(clk_i),
    .rst_i(rst_i), .link(link_a.dev), .step_i(step), .dir_i(dir), .status_i(status),
    .cfg_wr_o(cfg_wr), .cfg_idx_o(cfg_idx), .cfg_data_o(cfg_data), .mode_o(mode),
    .actual_position_o(pos));
  mcsp_dev #(.LUT_DEPTH(64), .LUT_AW(6)) mcsp_dev_x_i (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_b.dev), .step_i(step), .dir_i(dir), .status_i(status), .cfg_wr_o(),
    .cfg_idx_o(), .cfg_data_o(), .mode_o(), .actual_position_o(pos_b));
  mcsp_assertions mcsp_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(link_a.sclk),
    .cs_n(link_a.cs_n), .mosi(link_a.mosi), .miso(link_a.miso));

  // Count configuration strobes
  always @(posedge clk_i)
    if (cfg_wr === 1'b1)
      cfg_pulses <= cfg_pulses + 1;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat_w} <= {2'b11, we, sel_v, adr, wd};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_r;
    {wb_cyc, wb_stb} <= 2'b00;
    if (wb_ack !== 1'b1)
    begin
      chk("wb_ack", 32'h1, 32'h0);
      test_done();
    end
  endtask

  // Wait for the running datagram to end, optionally checking what came back
  task automatic wait_rx(input logic [31:0] exp, input bit cmp);
    logic [31:0] rd;
    for (int n = 0; n <= 400; n++)
    begin
      wb(1'b0, HOFS_STATUS, 32'h0, rd);
      if (rd[HSTAT_DONE] === 1'b1 && rd[HSTAT_BUSY] === 1'b0)
        break;
      if (n == 400)
      begin
        chk("frame_done", 32'h2, rd);
        test_done();
      end
    end
    wb(1'b0, HOFS_RXDATA, 32'h0, rd);
    if (cmp)
      chk("rx_data", exp, rd);
    repeat (6) @(posedge clk_i);
  endtask

  // One datagram through the host end
  task automatic frame(input logic [7:0] ab, input logic [31:0] d, input logic [31:0] exp,
                       input bit cmp);
    logic [31:0] rd;
    wb(1'b1, HOFS_TXDATA, d, rd);
    wb(1'b1, HOFS_CTRL, {24'h0, ab}, rd);
    wait_rx(exp, cmp);
  endtask

  // Hand-driven frame on the second link, possibly cut short or run long
  task automatic bang(input logic [39:0] dg_v, input int nbits);
    @(posedge clk_i);
    link_b.cs_n <= 1'b0;
    for (int i = 39; i > 39 - nbits; i--)
    begin
      link_b.mosi <= (i >= 0) ? dg_v[i] : 1'b0;
      repeat (4) @(posedge clk_i);
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      link_b.sclk <= 1'b0;
    end
    link_b.mosi <= ~link_b.mosi;
    repeat (4) @(posedge clk_i);
    link_b.cs_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] rd;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("mode", MODE_RESET, mode);
    chk("position", POS_RESET, pos);
    frame(8'h01, 32'hffff_ffff, POS_RESET, 1'b1);
    chk("position", POS_RESET, pos);
    frame(8'h81, 32'h89ab_cdef, 32'h0, 1'b0);
    chk("position", 32'h89ab_cdef, pos);
    frame(8'h01, 32'h0, 32'h89ab_cdef, 1'b1);
    tend("position");
    bang(40'h81_1357_9bdf, 39);
    chk("short frame", POS_RESET, pos_b);
    bang(40'h81_1357_9bdf, 40);
    chk("full frame", 32'h1357_9bdf, pos_b);
    bang(40'h81_0246_8ace, 41);
    chk("long frame", 32'h1357_9bdf, pos_b);
    tend("framing");
    frame({1'b1, REG_MODE}, 32'h0000_0305, 32'h0, 1'b0);
    chk("mode", 32'h0000_0305, mode);
    frame({1'b0, REG_MODE}, 32'h0, 32'h0000_0305, 1'b1);
    frame(8'h83, 32'h1234_5678, 32'h0, 1'b0);
    chk("cfg_pulses", 32'h1, cfg_pulses);
    chk("cfg_idx", 32'h3, {25'h0, cfg_idx});
    chk("cfg_data", 32'h1234_5678, cfg_data);
    frame(8'h03, 32'h0, 32'h0, 1'b1);
    frame({1'b0, REG_STATUS}, 32'h0, status, 1'b1);
    frame({1'b0, REG_TYPE_VERSION}, 32'h0, ID_VAL, 1'b1);
    wb(1'b1, HOFS_TXDATA, 32'h0, rd);
    wb(1'b1, HOFS_CTRL, 32'h0000_0001, rd);
    wb(1'b1, HOFS_CTRL, 32'h0000_0083, rd);
    wb(1'b0, HOFS_STATUS, 32'h0, rd);
    chk("busy status", 32'h1, rd);
    wait_rx(32'h89ab_cdef, 1'b1);
    chk("cfg_pulses", 32'h1, cfg_pulses);
    tend("registers");
    frame(8'h81, 32'hffff_fffe, 32'h0, 1'b0);
    step <= 1'b1;
    repeat (3) @(posedge clk_i);
    step <= 1'b0;
    repeat (2) @(posedge clk_i);
    frame(8'h01, 32'h0, 32'h0000_0001, 1'b1);
    dir  <= 1'b1;
    step <= 1'b1;
    repeat (2) @(posedge clk_i);
    step <= 1'b0;
    dir  <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("position", 32'hffff_ffff, pos);
    tend("signed position");
    frame({1'b1, REG_LUT_PTR}, 32'h0, 32'h0, 1'b0);
    foreach (lut[k])
      frame({1'b1, REG_LUT_WR}, lut[k], 32'h0, 1'b0);
    frame({1'b1, REG_LUT_PTR}, 32'h0, 32'h0, 1'b0);
    frame({1'b0, REG_LUT_RD}, 32'h0, 32'h0, 1'b1);
    foreach (lut[k])
      frame({1'b0, REG_LUT_RD}, 32'h0, lut[k], 1'b1);
    tend("table");
    wb(1'b1, HOFS_RXDATA, 32'hdead_beef, rd);
    wb(1'b0, HOFS_RXDATA, 32'h0, rd);
    chk("rxdata", lut[2], rd);
    wb(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    sel_v = 4'h1;
    wb(1'b1, HOFS_TXDATA, 32'hffff_ffff, rd);
    sel_v = 4'hf;
    wb(1'b0, HOFS_TXDATA, 32'h0, rd);
    chk("txdata", 32'h0000_00ff, rd);
    tend("host registers");
    test_done();
  end
endmodule
